// [logic/pwc_pkg.sv]
// Constants shared by the pulse width and period capture block.
// Assumes an 8-bit special-register style port with paged addresses.
package pwc_pkg;
    // Register offsets
    localparam logic [7:0] PERIOD_LO_ADDR = 8'hD9;
    localparam logic [7:0] PERIOD_HI_ADDR = 8'hDA;
    localparam logic [7:0] HIGH_LO_ADDR   = 8'hDB;
    localparam logic [7:0] HIGH_HI_ADDR   = 8'hDC;
    localparam logic [7:0] CONTROL_ADDR   = 8'hDD;
    // Page select values
    localparam logic       PAGE_PIN       = 1'b0;
    localparam logic       PAGE_SOFT      = 1'b1;
    // Control field positions
    localparam int         ENABLE_BIT     = 7;
    localparam int         DONE_BIT       = 6;
    localparam int         INPUT_BIT      = 4;
    localparam int         CLEAR_BIT      = 3;
    localparam int         CKSEL_MSB      = 2;
    // Reset values
    localparam logic [7:0] CONTROL_RESET  = 8'h03;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    // Counting clock: source and base divider
    localparam int         SOURCE_MHZ     = 48;
    localparam int         BASE_DIV_LOG2  = 2;
endpackage : pwc_pkg

// [logic/pwc_channel.sv]
// One capture channel: edge detection, high and period counters, results.
// Assumes a sampled input already in the clk domain and a tick enable.
`timescale 1ns/1ps
module pwc_channel #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             enable,      // Channel enable
    input  wire logic             sig_in,      // Sampled measured level
    input  wire logic             tick,        // One counting-clock tick
    output logic      [WIDTH-1:0] period_ff,   // Readable period count
    output logic      [WIDTH-1:0] high_ff,     // Readable high count
    output logic                  capture      // Measurement completed pulse
);
    logic             sig_d_ff;     // Previous input level
    logic             armed_ff;     // First rising edge seen
    logic [WIDTH-1:0] per_cnt_ff;   // Running period count
    logic [WIDTH-1:0] hi_cnt_ff;    // Running high count
    logic [WIDTH-1:0] hi_lat_ff;    // High count latched at fall
    logic             rise;
    logic             fall;
    logic [WIDTH-1:0] max_cnt;

    assign max_cnt = '1;
    assign rise    = enable && sig_in && !sig_d_ff;
    assign fall    = enable && !sig_in && sig_d_ff;
    // Completion only once a full period has been framed
    assign capture = rise && armed_ff;

    // Edge reference
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sig_d_ff <= 1'b0;
        end else begin
            sig_d_ff <= sig_in;
        end
    end

    // Armed after first rising edge while enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_ff <= 1'b0;
        end else if (!enable) begin
            armed_ff <= 1'b0;
        end else if (rise) begin
            armed_ff <= 1'b1;
        end
    end

    // Period counter, restarts on each rising edge, saturates
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt_ff <= '0;
        end else if (!enable) begin
            per_cnt_ff <= '0;
        end else if (rise) begin
            per_cnt_ff <= '0;
        end else if (armed_ff && tick && per_cnt_ff != max_cnt) begin
            per_cnt_ff <= per_cnt_ff + 1'b1;
        end
    end

    // High counter, runs while input is high inside a period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_cnt_ff <= '0;
        end else if (!enable || rise) begin
            hi_cnt_ff <= '0;
        end else if (armed_ff && sig_in && tick && hi_cnt_ff != max_cnt) begin
            hi_cnt_ff <= hi_cnt_ff + 1'b1;
        end
    end

    // Latch high count on falling edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_lat_ff <= '0;
        end else if (!enable) begin
            hi_lat_ff <= '0;
        end else if (fall && armed_ff) begin
            hi_lat_ff <= hi_cnt_ff;
        end
    end

    // Publish both results together at capture
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_ff <= pwc_pkg::COUNT_RESET;
            high_ff   <= pwc_pkg::COUNT_RESET;
        end else if (capture) begin
            period_ff <= per_cnt_ff;
            high_ff   <= hi_lat_ff;
        end
    end
endmodule : pwc_channel

// [logic/pwc_top.sv]
// Pulse width and period capture with a pin channel and a soft channel.
// Assumes an 8-bit register port with one-cycle read/write strobes,
// a page select from outside, and pins asynchronous to clk.
`timescale 1ns/1ps
module pwc_top #(
    parameter int WIDTH    = 16,
    parameter int DIV_BITS = 10   // Divider width, covers the largest divide
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       register_page_select,  // 0 pin channel, 1 soft channel
    input  wire logic [7:0] reg_addr,              // Register address
    input  wire logic       reg_wr,                // Write strobe
    input  wire logic       reg_rd,                // Read strobe
    input  wire logic [7:0] reg_wdata,             // Write data
    output logic      [7:0] reg_rdata_ff,          // Read data
    input  wire logic       measure_pin_a,         // First capture pin
    input  wire logic       measure_pin_b,         // Second capture pin
    output logic            capture_irq_ff         // Shared capture interrupt
);
    // Channel index 0 pin, 1 soft
    logic [7:0]       ctrl_ff   [2];   // Stored control bits (no done, no clear)
    logic [1:0]       done_ff;         // Done flags
    logic [1:0]       capture;         // Completion pulses
    logic [1:0]       sig;             // Per-channel sampled input
    logic [1:0]       tick;            // Per-channel counting tick
    logic [WIDTH-1:0] period   [2];
    logic [WIDTH-1:0] high     [2];
    logic [DIV_BITS-1:0] div_ff;       // Free-running divider of the count base
    logic             pin_a_s1_ff;     // Synchroniser stage one
    logic             pin_a_s2_ff;     // Synchroniser stage two
    logic             pin_b_s1_ff;
    logic             pin_b_s2_ff;
    logic             sel_ch;          // Addressed channel
    logic [7:0]       rd_next;         // Combinational read mux

    assign sel_ch = register_page_select;

    // Two-stage synchronisers on both pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_a_s1_ff <= 1'b0;
            pin_a_s2_ff <= 1'b0;
            pin_b_s1_ff <= 1'b0;
            pin_b_s2_ff <= 1'b0;
        end else begin
            pin_a_s1_ff <= measure_pin_a;
            pin_a_s2_ff <= pin_a_s1_ff;
            pin_b_s1_ff <= measure_pin_b;
            pin_b_s2_ff <= pin_b_s1_ff;
        end
    end

    // Input selection per channel
    assign sig[0] = ctrl_ff[0][pwc_pkg::INPUT_BIT] ? pin_a_s2_ff : pin_b_s2_ff;
    assign sig[1] = ctrl_ff[1][pwc_pkg::INPUT_BIT];

    // Free-running divider producing tick sources
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Per-channel logic
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [3:0] shift;   // log2 of divide in clk periods scale
        logic [DIV_BITS-1:0] mask;
        // Divide = 2^(code+2) of the 48 MHz base, expressed in clk cycles
        assign shift = 4'(ctrl_ff[c][pwc_pkg::CKSEL_MSB:0]) + 4'(pwc_pkg::BASE_DIV_LOG2);
        assign mask  = DIV_BITS'((1 << shift) - 1);
        // Tick once per selected period, approximated on the clk grid
        assign tick[c] = ((div_ff & mask) == '0);

        pwc_channel #(
            .WIDTH (WIDTH)
        ) u_ch (
            .clk       (clk),
            .reset_n   (reset_n),
            .enable    (ctrl_ff[c][pwc_pkg::ENABLE_BIT]),
            .sig_in    (sig[c]),
            .tick      (tick[c]),
            .period_ff (period[c]),
            .high_ff   (high[c]),
            .capture   (capture[c])
        );

        // Control storage, done and clear handled apart
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ctrl_ff[c] <= pwc_pkg::CONTROL_RESET;
            end else if (reg_wr && reg_addr == pwc_pkg::CONTROL_ADDR && sel_ch == 1'(c)) begin
                ctrl_ff[c] <= {reg_wdata[7], 1'b0, 1'b0, reg_wdata[4], 1'b0, reg_wdata[2:0]};
            end
        end

        // Done flag: set wins over write-one clear
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                done_ff[c] <= 1'b0;
            end else if (capture[c]) begin
                done_ff[c] <= 1'b1;
            end else if (reg_wr && reg_addr == pwc_pkg::CONTROL_ADDR && sel_ch == 1'(c)
                         && reg_wdata[pwc_pkg::CLEAR_BIT]) begin
                done_ff[c] <= 1'b0;
            end
        end
    end

    // Shared interrupt: registered OR of both channels' completion pulses, one pulse when both complete in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_irq_ff <= 1'b0;
        end else begin
            capture_irq_ff <= |capture;
        end
    end

    // Read mux for the selected page
    always_comb begin
        rd_next = 8'h00;
        case (reg_addr)
            pwc_pkg::PERIOD_LO_ADDR: rd_next = period[sel_ch][7:0];
            pwc_pkg::PERIOD_HI_ADDR: rd_next = period[sel_ch][15:8];
            pwc_pkg::HIGH_LO_ADDR:   rd_next = high[sel_ch][7:0];
            pwc_pkg::HIGH_HI_ADDR:   rd_next = high[sel_ch][15:8];
            pwc_pkg::CONTROL_ADDR:   rd_next = {ctrl_ff[sel_ch][7], done_ff[sel_ch], 1'b0,
                                                ctrl_ff[sel_ch][4], 1'b0, ctrl_ff[sel_ch][2:0]};
            default:                 rd_next = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= rd_next;
        end
    end
endmodule : pwc_top

// [tb/pwc_monitor.sv]
// Checker on the capture block register port and interrupt line.
// Sees only pwc_top ports; bound to every instance below.
`timescale 1ns/1ps
module pwc_monitor (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       register_page_select,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic       capture_irq_ff
);
    wire logic ctl_wr = reg_wr && reg_addr == pwc_pkg::CONTROL_ADDR;  // Control write
    wire logic ctl_rd = reg_rd && reg_addr == pwc_pkg::CONTROL_ADDR;  // Control read
    logic      irq_seen_ff;                                           // Capture since reset
    logic      wr_seen_ff;                                            // Control write since reset
    logic      en_seen_ff;                                            // Enabling write since reset
    // Sticky history, cleared only by reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_seen_ff <= 1'b0;
            wr_seen_ff  <= 1'b0;
            en_seen_ff  <= 1'b0;
        end else begin
            irq_seen_ff <= irq_seen_ff | capture_irq_ff;
            wr_seen_ff  <= wr_seen_ff | ctl_wr;
            en_seen_ff  <= en_seen_ff | (ctl_wr & reg_wdata[7]);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Control write, then control read on the same page
    sequence s_wr_rd; ctl_wr ##1 (ctl_rd && $stable(register_page_select)); endsequence
    // Clearing write with channel off, then control read
    sequence s_clr_rd;
        (ctl_wr && reg_wdata[3] && !reg_wdata[7]) ##1 (ctl_rd && $stable(register_page_select));
    endsequence
    property p_ctl_back; s_wr_rd |=> (reg_rdata_ff & 8'h97) == ($past(reg_wdata, 2) & 8'h97); endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback differs");
    property p_clr_done; s_clr_rd |=> !reg_rdata_ff[6]; endproperty
    a_clr_done: assert property (p_clr_done) else $error("done flag not cleared");
    property p_unmapped; reg_rd && !(reg_addr inside {[8'hD9:8'hDD]}) |=> reg_rdata_ff == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctl_zero; ctl_rd |=> !reg_rdata_ff[5] && !reg_rdata_ff[3]; endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control bits 5 or 3 read one");
    property p_cnt_reset;
        reg_rd && reg_addr inside {[8'hD9:8'hDC]} && !irq_seen_ff |=> reg_rdata_ff == 8'h00;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("count not zero before capture");
    property p_ctl_reset; ctl_rd && !wr_seen_ff |=> reg_rdata_ff == pwc_pkg::CONTROL_RESET; endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value wrong");
    property p_no_irq; !en_seen_ff |-> !capture_irq_ff; endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt while never enabled");
    property p_irq_pulse; capture_irq_ff |=> !capture_irq_ff; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
endmodule : pwc_monitor
bind pwc_top pwc_monitor u_mon (.clk, .reset_n, .register_page_select, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_ff, .capture_irq_ff);

// [tb/pwc_wave_model.sv]
// Square-wave source on the measure pins, low then high each period.
// Assumes lengths in clk cycles; the unused pin toggles every cycle.
`timescale 1ns/1ps
module pwc_wave_model (
    input wire logic clk,
    input wire logic run,     // Produce the waveform
    input wire logic use_a,   // Waveform on pin a, else pin b
    input int        hi_cyc,  // High length
    input int        lo_cyc,  // Low length
    output logic     pin_a,
    output logic     pin_b
);
    int   cnt   = 0;     // Position within the period
    logic noise = 1'b0;  // Junk on the unused pin
    logic wave;          // Measured level
    // Pins move off the sampling edge, like a real source
    always @(negedge clk) begin
        noise <= ~noise;
        cnt   <= (!run || cnt >= hi_cyc + lo_cyc - 1) ? 0 : cnt + 1;
    end
    assign wave  = run && cnt >= lo_cyc;
    assign pin_a = use_a ? wave : noise;
    assign pin_b = use_a ? noise : wave;
endmodule : pwc_wave_model

// [tb/pwc_top_tb_top.sv]
// Self-checking bench: reset values, soft channel on all clock codes, pin channel.
// Assumes the wave model on the pins; inputs change at the falling edge.
`timescale 1ns/1ps
module pwc_top_tb_top;
    localparam logic [7:0] CTL = pwc_pkg::CONTROL_ADDR;
    logic       clk = 1'b0, reset_n = 1'b0, page = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
    logic       pin_a, pin_b, irq, run = 1'b0, use_a = 1'b0;
    int         n_fail = 0, samples_checked = 0;
    initial forever #20 clk = ~clk;
    pwc_top dut (.clk(clk), .reset_n(reset_n), .register_page_select(page), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .measure_pin_a(pin_a),
        .measure_pin_b(pin_b), .capture_irq_ff(irq));
    pwc_wave_model u_wave (.clk(clk), .run(run), .use_a(use_a), .hi_cyc(40), .lo_cyc(24), .pin_a(pin_a),
        .pin_b(pin_b));
    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
        samples_checked++;
        if ((^seen) === 1'bx || (tol == 0 && seen !== exp) || seen > exp + tol || seen + tol < exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
        page = pg; reg_addr = a; reg_wdata = d; reg_rd = 1'b0; reg_wr = 1'b1;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic pg, input logic [7:0] a, output logic [7:0] q);
        page = pg; reg_addr = a; reg_wr = 1'b0; reg_rd = 1'b1;
        @(negedge clk);
        q = reg_rdata_ff;
    endtask : rd
    task automatic expect_rd(input logic pg, input logic [7:0] a, input logic [7:0] e, input int tol);
        logic [7:0] q;
        rd(pg, a, q);
        check({8'h00, q}, {8'h00, e}, tol);
    endtask : expect_rd
    task automatic expect16(input logic pg, input logic [7:0] a, input logic [15:0] e);
        logic [7:0] lo, hi;
        rd(pg, a, lo);
        rd(pg, a + 8'h01, hi);
        check({hi, lo}, e, 1);
    endtask : expect16
    task automatic idle(input int n);
        reg_wr = 1'b0; reg_rd = 1'b0;
        repeat (n) @(negedge clk);
    endtask : idle
    // Bounded wait for the shared interrupt
    task automatic wait_irq(input int n);
        idle(0);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(negedge clk);
        if (irq !== 1'b1) begin
            n_fail++;
            final_report();
        end
    endtask : wait_irq
    // Every address on both pages, plus one unmapped
    task automatic reset_values();
        for (int p = 0; p < 2; p++)
            for (int a = 'hD9; a <= 'hDE; a++)
                expect_rd(p[0], 8'(a), a == 'hDD ? 8'h03 : 8'h00, 0);
    endtask : reset_values
    // Soft level 10 ticks high, 6 low, slow enough per code
    task automatic soft_all_codes();
        int t;
        for (int c = 0; c < 8; c++) begin
            t = 4 << c;
            wr(1'b1, CTL, 8'h80 | 8'(c));
            idle(t);
            wr(1'b1, CTL, 8'h90 | 8'(c));
            idle(10 * t - 1);
            wr(1'b1, CTL, 8'h80 | 8'(c));
            idle(6 * t - 1);
            wr(1'b1, CTL, 8'h90 | 8'(c));
            wait_irq(2 * t + 20);
            expect_rd(1'b1, CTL, 8'hD0 | 8'(c), 0);
            expect16(1'b1, pwc_pkg::PERIOD_LO_ADDR, 16'h0010);
            expect16(1'b1, pwc_pkg::HIGH_LO_ADDR, 16'h000A);
            wr(1'b1, CTL, 8'h08 | 8'(c));
            expect_rd(1'b1, CTL, 8'(c), 0);
            expect_rd(1'b0, CTL, 8'h03, 0);
        end
    endtask : soft_all_codes
    // Pin a then pin b, junk toggling on the other pin
    task automatic pin_channel();
        logic [7:0] q;
        for (int s = 1; s >= 0; s--) begin
            use_a = s[0];
            run = 1'b1;
            wr(1'b0, CTL, s[0] ? 8'h90 : 8'h80);
            wait_irq(400);
            expect_rd(1'b0, CTL, s[0] ? 8'hD0 : 8'hC0, 0);
            expect16(1'b0, pwc_pkg::PERIOD_LO_ADDR, 16'h0010);
            expect16(1'b0, pwc_pkg::HIGH_LO_ADDR, 16'h000A);
            rd(1'b0, pwc_pkg::PERIOD_LO_ADDR, q);
            wr(1'b0, pwc_pkg::PERIOD_LO_ADDR, ~q);
            expect_rd(1'b0, pwc_pkg::PERIOD_LO_ADDR, q, 0);
            run = 1'b0;
            wr(1'b0, CTL, 8'h08);
            expect_rd(1'b0, CTL, 8'h00, 0);
        end
    endtask : pin_channel
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        reset_values();
        soft_all_codes();
        pin_channel();
        final_report();
    end
endmodule : pwc_top_tb_top
